//--- system_reset_defines.svh
// Register offsets, field positions, reset values and timing figures of the reset controller
`ifndef SYSTEM_RESET_DEFINES_SVH
`define SYSTEM_RESET_DEFINES_SVH

`define OFS_CAUSE      8'h00
`define OFS_BOR_CTRL   8'h04
`define OFS_APP_RST    8'h08
`define OFS_WDT_CTRL   8'h0c
`define OFS_INT_STAT   8'h10
`define OFS_INT_MASK   8'h14
`define OFS_IDENT0     8'h18
`define OFS_IDENT1     8'h1c
`define OFS_CAPS       8'h20
`define OFS_SRCR0      8'h40

`define CAUSE_EXT      0
`define CAUSE_POR      1
`define CAUSE_BOR      2
`define CAUSE_WDT      3
`define CAUSE_SW       4
`define CAUSE_MAIN_OSC     16
`define CAUSE_POR_ONLY 32'h0000_0002

`define BOR_EN_BIT     1
`define SYSREQ_BIT     2
`define WDT_EN_BIT     0
`define INT_BOR        0
`define INT_MAIN_OSC       1

`define CLK_PERIOD_NS  20
`define RST_HOLD_NS    200
`define PERIPH_HOLD_NS 320

`define RESP_OKAY      2'b00
`define RESP_SLVERR    2'b10

`endif

//--- system_reset_pkg.sv
// Types shared by the reset controller modules
package system_reset_pkg;
  typedef enum logic [1:0] {
    SEQ_RUN  = 2'b01,
    SEQ_HOLD = 2'b10
  } seq_state_t;

  typedef enum logic [1:0] {
    WD_IDLE  = 2'b01,
    WD_ARMED = 2'b10
  } wd_state_t;

  typedef logic [31:0] word_t;
endpackage

//--- reset_release.sv
// Holds the system reset for a fixed time after the last request and releases it on one edge
module reset_release #(
  parameter int HOLD_CYCLES = 10
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic req,
  output logic      rst_n,
  output logic      release_pulse
);
  import system_reset_pkg::*;

  localparam int CW = $clog2(HOLD_CYCLES + 1);

  typedef struct packed {
    seq_state_t     st;
    logic [CW-1:0]  cnt;
    logic           rst_n;
    logic           rel;
  } rr_state_t;

  rr_state_t s;
  rr_state_t next_s;

  if (HOLD_CYCLES < 1) begin : g_chk
    $error("reset_release: HOLD_CYCLES must be at least 1");
  end

  always_comb begin
    next_s = s;
    next_s.rel = 1'b0;
    unique case (s.st)
      SEQ_RUN: begin
        if (req) begin
          next_s.st = SEQ_HOLD;
          next_s.rst_n = 1'b0;
          next_s.cnt = CW'(HOLD_CYCLES - 1);
        end
      end
      SEQ_HOLD: begin
        // A request still present restarts the hold
        if (req) begin
          next_s.cnt = CW'(HOLD_CYCLES - 1);
        end else if (s.cnt == '0) begin
          next_s.st = SEQ_RUN;
          next_s.rst_n = 1'b1;
          next_s.rel = 1'b1;
        end else begin
          next_s.cnt = s.cnt - 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.st <= SEQ_HOLD;
      s.cnt <= CW'(HOLD_CYCLES - 1);
    end else begin
      s <= next_s;
    end
  end

  assign rst_n = s.rst_n;
  assign release_pulse = s.rel;
endmodule

//--- periph_reset_gen.sv
// Per-peripheral software resets, held while the control bit is set and stretched after its clear
module periph_reset_gen #(
  parameter int N            = 96,
  parameter int PULSE_CYCLES = 16
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [N-1:0] ctrl,
  output logic      [N-1:0] rst_n
);
  import system_reset_pkg::*;

  localparam int CW = $clog2(PULSE_CYCLES + 1);

  if (N < 1 || PULSE_CYCLES < 1) begin : g_chk
    $error("periph_reset_gen: N and PULSE_CYCLES must be at least 1");
  end

  for (genvar i = 0; i < N; i++) begin : g_bit
    typedef struct packed {
      logic [CW-1:0] cnt;
      logic          rst_n;
    } pr_state_t;

    pr_state_t s;
    pr_state_t next_s;

    // Stretch lets slow clock domains of the unit see the reset too
    always_comb begin
      next_s = s;
      if (ctrl[i]) begin
        next_s.rst_n = 1'b0;
        next_s.cnt = CW'(PULSE_CYCLES - 1);
      end else if (!s.rst_n) begin
        if (s.cnt == '0) begin
          next_s.rst_n = 1'b1;
        end else begin
          next_s.cnt = s.cnt - 1'b1;
        end
      end
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        s <= '0;
        s.rst_n <= 1'b1;
      end else begin
        s <= next_s;
      end
    end

    assign rst_n[i] = s.rst_n;
  end
endmodule

//--- system_reset_control.sv
// Reset source combiner, release sequencer, cause flags and AXI4-Lite register file
//
// Chosen here: the register offsets and register access over AXI4-Lite.
`include "system_reset_defines.svh"

// How it works
// R1: Six reset sources are combined: pin, power-on, brown-out, software, watchdog, oscillator.
// R2: Power-on reset drives core, peripherals and debug port reset together.
// R3: Pin reset hits core and peripherals; debug port only sees pin configuration reset.
// R4: Each reset sets its cause flag; flags persist across later resets other than power-on.
// R5: Power-on reset leaves only the power-on cause flag set.
// R6: After power-on, internal reset holds until released, then core starts fetching.
// R7: Power-on reset comes only from the bus reset at power-up.
// R8: Outside party holds the pin low long enough; release then starts core.
// R9: Brown-out reset enable is clear after power-on.
// R10: Brown-out resets only when enabled; otherwise it raises an interrupt.
// R11: Enabled brown-out acts like pin reset and holds while supply stays low.
// R12: Setting then clearing a peripheral bit resets that peripheral.
// R13: Peripheral reset bit positions follow the clock gating bit layout.
// R14: Peripheral software resets reach all unit domains, never core or debug.
// R15: System reset request bit resets the whole system, then releases the core.
// R16: Identification and capability registers are read-only.
// R17: Oscillator failure resets the system, flags it and requests the NMI.
// R18: Watchdog resets only on second unserviced time-out with reset enabled.
// R19: Core and peripheral resets are released synchronously on one clock edge.
module system_reset_control #(
  parameter int                    ADDR_W   = 8,
  parameter int                    NUM_SRCR = 3,
  parameter system_reset_pkg::word_t IDENT0 = 32'h0001_0000, // Arbitrary value
  parameter system_reset_pkg::word_t IDENT1 = 32'h1000_0001, // Arbitrary value
  parameter system_reset_pkg::word_t CAPS   = 32'h0000_00ff, // Arbitrary value
  parameter int HOLD_CYCLES   = (`RST_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int PERIPH_CYCLES = (`PERIPH_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic [ADDR_W-1:0]          awaddr,
  input  wire logic [2:0]                 awprot,
  input  wire logic                       awvalid,
  output logic                            awready,
  input  wire system_reset_pkg::word_t    wdata,
  input  wire logic [3:0]                 wstrb,
  input  wire logic                       wvalid,
  output logic                            wready,
  output logic [1:0]                      bresp,
  output logic                            bvalid,
  input  wire logic                       bready,
  input  wire logic [ADDR_W-1:0]          araddr,
  input  wire logic [2:0]                 arprot,
  input  wire logic                       arvalid,
  output logic                            arready,
  output system_reset_pkg::word_t         rdata,
  output logic [1:0]                      rresp,
  output logic                            rvalid,
  input  wire logic                       rready,
  input  wire logic                       ext_rst_n,
  input  wire logic                       brownout_detect,
  input  wire logic                       wdt_timeout,
  input  wire logic                       wdt_service,
  input  wire logic                       main_osc_fail,
  output logic                            core_rst_n,
  output logic                            tap_rst_n,
  output logic                            tap_pin_cfg_rst_n,
  output logic [32*NUM_SRCR-1:0]          periph_rst_n,
  output logic                            nmi_req,
  output logic                            irq
);
  import system_reset_pkg::*;

  localparam int NP = 32 * NUM_SRCR;

  if (ADDR_W < 8 || NUM_SRCR < 1 || NUM_SRCR > 8) begin : g_chk
    $error("system_reset_control: ADDR_W >= 8 and NUM_SRCR in 1..8 required");
  end

  typedef struct packed {
    logic          awready;
    logic          wready;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          arready;
    logic          rvalid;
    logic [1:0]    rresp;
    word_t         rdata;
    logic          have_aw;
    logic          have_w;
    logic [7:0]    waddr;
    word_t         wdata;
    logic [3:0]    wstrb;
    word_t         cause;
    word_t         int_stat;
    word_t         int_mask;
    logic          bor_en;
    logic          wdt_en;
    logic          sysreq;
    logic [NP-1:0] srcr;
    wd_state_t     wd;
    logic          bor_prev;
    logic          main_osc_pend;
    logic          nmi;
    logic          irq;
    logic          core_rst_n;
    logic          tap_rst_n;
    logic          pin_rst_n;
    logic [NP-1:0] periph_rst_n;
  } sc_state_t;

  sc_state_t     s;
  sc_state_t     next_s;
  logic          sys_req;
  logic          sys_rst_n;
  logic          rel_pulse;
  logic [NP-1:0] sw_rst_n;
  logic          bor_act;
  logic          wdt_fire;

  // Enabled brown-out is a level: reset holds while the supply is low
  assign bor_act = brownout_detect & s.bor_en; // [R10] [R11]
  assign wdt_fire = (s.wd == WD_ARMED) & wdt_timeout & s.wdt_en; // [R18]
  // Pin is taken as already held for its minimum width by the board
  assign sys_req = !ext_rst_n | bor_act | wdt_fire | s.sysreq | main_osc_fail; // [R1] [R8] [R15] [R17]

  reset_release #(
    .HOLD_CYCLES (HOLD_CYCLES)
  ) u_release (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .req           (sys_req),
    .rst_n         (sys_rst_n),
    .release_pulse (rel_pulse)
  );

  periph_reset_gen #(
    .N            (NP),
    .PULSE_CYCLES (PERIPH_CYCLES)
  ) u_periph (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ctrl    (s.srcr),
    .rst_n   (sw_rst_n)
  );

  always_comb begin
    word_t      wmask;
    word_t      rdv;
    word_t      set_cause;
    word_t      clr_cause;
    word_t      set_int;
    word_t      clr_int;
    logic       rerr;
    logic       werr;
    logic [7:0] ra;
    next_s = s;
    wmask = '0;
    rdv = '0;
    set_cause = '0;
    clr_cause = '0;
    set_int = '0;
    clr_int = '0;
    rerr = 1'b1;
    werr = 1'b1;
    ra = araddr[7:0];
    next_s.sysreq = 1'b0;
    next_s.nmi = 1'b0;
    for (int b = 0; b < 4; b++) begin
      wmask[8*b +: 8] = {8{s.wstrb[b]}};
    end

    // Write channels are taken in either order
    if (awvalid && s.awready) begin
      next_s.have_aw = 1'b1;
      next_s.waddr = awaddr[7:0];
    end
    if (wvalid && s.wready) begin
      next_s.have_w = 1'b1;
      next_s.wdata = wdata;
      next_s.wstrb = wstrb;
    end
    if (s.bvalid && bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s.have_aw && s.have_w && !s.bvalid) begin
      werr = 1'b0;
      unique case (s.waddr)
        `OFS_CAUSE: clr_cause = s.wdata & wmask;
        `OFS_BOR_CTRL: begin
          if (s.wstrb[0]) begin
            next_s.bor_en = s.wdata[`BOR_EN_BIT];
          end
        end
        `OFS_APP_RST: begin
          if (s.wstrb[0] && s.wdata[`SYSREQ_BIT]) begin
            next_s.sysreq = 1'b1; // [R15]
          end
        end
        `OFS_WDT_CTRL: begin
          if (s.wstrb[0]) begin
            next_s.wdt_en = s.wdata[`WDT_EN_BIT];
          end
        end
        `OFS_INT_STAT: clr_int = s.wdata & wmask;
        `OFS_INT_MASK: next_s.int_mask = (s.int_mask & ~wmask) | (s.wdata & wmask);
        `OFS_IDENT0, `OFS_IDENT1, `OFS_CAPS: werr = 1'b0; // [R16]
        default: begin
          werr = 1'b1;
          for (int j = 0; j < NUM_SRCR; j++) begin
            if (s.waddr == 8'(`OFS_SRCR0 + 4 * j)) begin
              // Word j bit k drives peripheral 32*j+k, as the clock gates do
              next_s.srcr[32*j +: 32] = (s.srcr[32*j +: 32] & ~wmask) | (s.wdata & wmask); // [R12] [R13]
              werr = 1'b0;
            end
          end
        end
      endcase
      next_s.have_aw = 1'b0;
      next_s.have_w = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = werr ? `RESP_SLVERR : `RESP_OKAY;
    end
    next_s.awready = !next_s.have_aw && !next_s.bvalid;
    next_s.wready = !next_s.have_w && !next_s.bvalid;

    // Read path answers on the same edge that takes the address
    if (s.rvalid && rready) begin
      next_s.rvalid = 1'b0;
    end
    if (arvalid && s.arready) begin
      rerr = 1'b0;
      unique case (ra)
        `OFS_CAUSE: rdv = s.cause;
        `OFS_BOR_CTRL: rdv[`BOR_EN_BIT] = s.bor_en;
        `OFS_APP_RST: rdv = '0;
        `OFS_WDT_CTRL: rdv[`WDT_EN_BIT] = s.wdt_en;
        `OFS_INT_STAT: rdv = s.int_stat;
        `OFS_INT_MASK: rdv = s.int_mask;
        `OFS_IDENT0: rdv = IDENT0; // [R16]
        `OFS_IDENT1: rdv = IDENT1;
        `OFS_CAPS: rdv = CAPS;
        default: begin
          rerr = 1'b1;
          for (int j = 0; j < NUM_SRCR; j++) begin
            if (ra == 8'(`OFS_SRCR0 + 4 * j)) begin
              rdv = s.srcr[32*j +: 32];
              rerr = 1'b0;
            end
          end
        end
      endcase
      next_s.rvalid = 1'b1;
      next_s.rdata = rdv;
      next_s.rresp = rerr ? `RESP_SLVERR : `RESP_OKAY;
    end
    next_s.arready = !next_s.rvalid;

    // Watchdog: first time-out arms, service disarms, second fires
    unique case (s.wd)
      WD_IDLE: begin
        if (wdt_timeout) begin
          next_s.wd = WD_ARMED;
        end
      end
      WD_ARMED: begin
        if (wdt_service) begin
          next_s.wd = WD_IDLE;
        end else if (wdt_fire) begin
          next_s.wd = WD_IDLE; // [R18]
        end
      end
    endcase

    // Cause flags: hardware set wins over a software clear
    set_cause[`CAUSE_EXT] = !ext_rst_n; // [R4]
    set_cause[`CAUSE_BOR] = bor_act;
    set_cause[`CAUSE_WDT] = wdt_fire;
    set_cause[`CAUSE_SW] = s.sysreq;
    set_cause[`CAUSE_MAIN_OSC] = main_osc_fail; // [R17]
    next_s.cause = (s.cause & ~clr_cause) | set_cause; // [R4]

    // Brown-out without reset enable becomes an interrupt event
    next_s.bor_prev = brownout_detect;
    set_int[`INT_BOR] = brownout_detect & !s.bor_prev & !s.bor_en; // [R10]
    set_int[`INT_MAIN_OSC] = main_osc_fail;
    next_s.int_stat = (s.int_stat & ~clr_int) | set_int;
    next_s.irq = |(next_s.int_stat & next_s.int_mask);

    // NMI is raised as the core leaves the oscillator-failure reset
    if (rel_pulse && s.main_osc_pend) begin
      next_s.nmi = 1'b1; // [R17]
      next_s.main_osc_pend = 1'b0;
    end
    if (main_osc_fail) begin
      next_s.main_osc_pend = 1'b1;
    end

    // System reset clears software reset bits and the watchdog
    if (!sys_rst_n) begin
      next_s.srcr = '0; // [R15]
      next_s.wd = WD_IDLE;
    end

    // All reset outputs leave one register stage on the same edge
    next_s.core_rst_n = sys_rst_n; // [R6] [R19]
    next_s.periph_rst_n = sw_rst_n & {NP{sys_rst_n}}; // [R14] [R19]
    next_s.pin_rst_n = ext_rst_n; // [R3]
    next_s.tap_rst_n = 1'b1; // [R3] [R7]
  end

  // Bus reset is the power-on reset: the only reset that clears cause flags and the debug port
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0; // [R2] [R9]
      s.cause <= `CAUSE_POR_ONLY; // [R5]
      s.wd <= WD_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign awready = s.awready;
  assign wready = s.wready;
  assign bresp = s.bresp;
  assign bvalid = s.bvalid;
  assign arready = s.arready;
  assign rdata = s.rdata;
  assign rresp = s.rresp;
  assign rvalid = s.rvalid;
  assign core_rst_n = s.core_rst_n;
  assign tap_rst_n = s.tap_rst_n;
  assign tap_pin_cfg_rst_n = s.pin_rst_n;
  assign periph_rst_n = s.periph_rst_n;
  assign nmi_req = s.nmi;
  assign irq = s.irq;
endmodule

//--- system_reset_control_sva.sv
// Port-level assertions for the reset controller
module system_reset_control_sva #(
  parameter int HOLD_CYCLES = 10,
  parameter int NUM_SRCR    = 3
) (
  input wire logic                    aclk,
  input wire logic                    aresetn,
  input wire logic                    ext_rst_n,
  input wire logic                    main_osc_fail,
  input wire logic                    core_rst_n,
  input wire logic                    tap_rst_n,
  input wire logic                    tap_pin_cfg_rst_n,
  input wire logic [32*NUM_SRCR-1:0]  periph_rst_n,
  input wire logic                    nmi_req,
  input wire logic                    bvalid,
  input wire logic                    bready,
  input wire logic [1:0]              bresp,
  input wire logic                    rvalid,
  input wire logic                    rready,
  input wire system_reset_pkg::word_t rdata
);
  import system_reset_pkg::*;
  // Slack past the hold for the release flop stages
  localparam int HMAX = HOLD_CYCLES + 6;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_por_all: assert property ($rose(aresetn) |-> !tap_rst_n && !core_rst_n) else $error("por skipped");
  a_tap_kept: assert property ($past(aresetn) |-> tap_rst_n) else $error("tap reset");
  a_pin_cfg: assert property ($past(aresetn) |-> tap_pin_cfg_rst_n == $past(ext_rst_n)) else $error("pin cfg");
  a_pin_reset: assert property (!ext_rst_n |-> ##2 !core_rst_n) else $error("pin no reset");
  a_pin_release: assert property ($rose(ext_rst_n) |-> !core_rst_n ##[1:HMAX] core_rst_n) else $error("no release");
  a_core_periph: assert property (!core_rst_n |-> periph_rst_n == '0) else $error("periph not in reset");
  a_osc_reset: assert property (main_osc_fail |-> ##2 !core_rst_n) else $error("osc no reset");
  a_nmi_pulse: assert property (nmi_req |=> !nmi_req) else $error("nmi long");
  a_b_stands: assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("b dropped");
  a_r_stands: assert property (rvalid && !rready |=> rvalid && $stable(rdata)) else $error("r dropped");
endmodule

bind system_reset_control system_reset_control_sva #(.HOLD_CYCLES(HOLD_CYCLES), .NUM_SRCR(NUM_SRCR)) sva (
  .aclk, .aresetn, .ext_rst_n, .main_osc_fail, .core_rst_n, .tap_rst_n, .tap_pin_cfg_rst_n,
  .periph_rst_n, .nmi_req, .bvalid, .bready, .bresp, .rvalid, .rready, .rdata);

//--- core_model.sv
// Core stand-in: counts vector fetches started by each reset release
module core_model (
  input wire logic aclk,
  input wire logic core_rst_n,
  output int       boots
);
  timeunit 1ns;
  timeprecision 1ns;
  int   cnt  = 0;
  logic prev = 1'h0;
  assign boots = cnt;
  always @(posedge aclk) begin
    if (core_rst_n && !prev) cnt <= cnt + 1;
    prev <= core_rst_n;
  end
endmodule

//--- system_reset_control_test.sv
// Self-checking bench of the reset controller
`include "system_reset_defines.svh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin miscompares++; \
  $display("mismatch t=%0t got %h exp %h", $time, a, e); end end
module system_reset_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  import system_reset_pkg::*;
  localparam word_t ID0 = 32'h0001_0000; // Arbitrary value
  logic        aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic        arvalid = 1'h0, rready = 1'h0, ext_rst_n = 1'h1, brownout_detect = 1'h0;
  logic        wdt_timeout = 1'h0, wdt_service = 1'h0, main_osc_fail = 1'h0, nmi_seen = 1'h0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [2:0]  awprot = 3'h0, arprot = 3'h0;
  logic [3:0]  wstrb = 4'hf;
  word_t       wdata = 32'h0, rdata, d;
  logic        awready, wready, bvalid, arready, rvalid, core_rst_n, tap_rst_n, tap_pin_cfg_rst_n, nmi_req, irq;
  logic [1:0]  bresp, rresp, r;
  logic [95:0] periph_rst_n;
  int          miscompares = 0, checks = 0, boots, b0;

  system_reset_control #(.HOLD_CYCLES(2), .PERIPH_CYCLES(2), .IDENT0(ID0)) dut (
    .aclk, .aresetn, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .ext_rst_n, .brownout_detect, .wdt_timeout, .wdt_service, .main_osc_fail, .core_rst_n,
    .tap_rst_n, .tap_pin_cfg_rst_n, .periph_rst_n, .nmi_req, .irq);
  core_model core (.aclk, .core_rst_n, .boots);

  initial forever #10 aclk = ~aclk;
  always @(posedge aclk) if (nmi_req === 1'h1) nmi_seen <= 1'h1;

  task automatic end_of_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic tmo(input int n);
    if (n >= 200) begin
      miscompares++;
      $display("mismatch t=%0t timeout %h %h", $time, n, 200);
      end_of_test();
    end
  endtask
  task automatic cycles(input int k);
    repeat (k) @(posedge aclk);
  endtask
  // Ready is sampled before the edge's updates land, so taken means valid and ready at that edge
  task automatic wr(input logic [7:0] a, input word_t v);
    int n; logic ad, wd;
    n = 0; ad = 0; wd = 0;
    awaddr <= a; wdata <= v; awvalid <= 1'h1; wvalid <= 1'h1;
    while (!(ad && wd) && n < 200) begin
      @(posedge aclk); n++;
      if (!ad && awready === 1'h1) begin ad = 1; awvalid <= 1'h0; end
      if (!wd && wready === 1'h1) begin wd = 1; wvalid <= 1'h0; end
    end
    while (bvalid !== 1'h1 && n < 200) begin @(posedge aclk); n++; end
    tmo(n);
    bready <= 1'h1; @(posedge aclk); r = bresp; bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    int n; n = 0;
    araddr <= a; arvalid <= 1'h1;
    do begin @(posedge aclk); n++; end while (arready !== 1'h1 && n < 200);
    arvalid <= 1'h0;
    while (rvalid !== 1'h1 && n < 200) begin @(posedge aclk); n++; end
    tmo(n);
    rready <= 1'h1; @(posedge aclk); d = rdata; r = rresp; rready <= 1'h0;
  endtask
  // Waits for the core model to see one more release
  task automatic wait_boot;
    int n; n = 0;
    while (boots == b0 && n < 200) begin @(posedge aclk); n++; end
    tmo(n);
    `CHK(boots, b0 + 1)
  endtask
  task automatic t_start;
    b0 = 0; wait_boot();
    rd(`OFS_CAUSE); `CHK(d, 32'h0000_0002)
    rd(`OFS_BOR_CTRL); `CHK(d, 32'h0)
    wr(`OFS_IDENT0, 32'hffff_ffff); `CHK(r, 2'h0)
    rd(`OFS_IDENT0); `CHK(d, ID0)
    wr(8'h30, 32'h1); `CHK(r, 2'h2)
    rd(8'h30); `CHK(r, 2'h2)
    `CHK({tap_rst_n, core_rst_n}, 2'h3)
  endtask
  task automatic t_pin;
    b0 = boots; ext_rst_n <= 1'h0; cycles(4);
    `CHK({core_rst_n, tap_rst_n, tap_pin_cfg_rst_n, |periph_rst_n}, 4'h4)
    ext_rst_n <= 1'h1; wait_boot();
    rd(`OFS_CAUSE); `CHK(d, 32'h3)
  endtask
  task automatic t_bor;
    b0 = boots; brownout_detect <= 1'h1; cycles(4); `CHK(core_rst_n, 1'h1)
    brownout_detect <= 1'h0; wr(`OFS_INT_MASK, 32'h1); cycles(2); `CHK(irq, 1'h1)
    wr(`OFS_INT_STAT, 32'h1); cycles(2); `CHK(irq, 1'h0)
    wr(`OFS_BOR_CTRL, 32'h2); brownout_detect <= 1'h1; cycles(8); `CHK(core_rst_n, 1'h0)
    brownout_detect <= 1'h0; wait_boot();
    rd(`OFS_CAUSE); `CHK(d, 32'h7)
  endtask
  task automatic tick(input logic to, input logic sv);
    wdt_timeout <= to; wdt_service <= sv; @(posedge aclk);
    wdt_timeout <= 1'h0; wdt_service <= 1'h0; cycles(3);
  endtask
  task automatic t_wdt;
    b0 = boots; wr(`OFS_WDT_CTRL, 32'h1);
    tick(1'h1, 1'h0); tick(1'h0, 1'h1); tick(1'h1, 1'h0); `CHK(boots, b0)
    tick(1'h1, 1'h0); wait_boot();
    rd(`OFS_CAUSE); `CHK(d, 32'hf)
  endtask
  task automatic t_sys;
    b0 = boots; wr(`OFS_APP_RST, 32'h4); wait_boot();
    rd(`OFS_CAUSE); `CHK(d, 32'h1f)
  endtask
  task automatic t_periph;
    b0 = boots; wr(`OFS_SRCR0 + 8'h04, 32'h20); cycles(2);
    `CHK(periph_rst_n, ~(96'h1 << 37))
    wr(`OFS_SRCR0 + 8'h04, 32'h0); cycles(6);
    `CHK(periph_rst_n, {96{1'h1}})
    `CHK(boots, b0)
  endtask
  task automatic t_osc;
    b0 = boots; main_osc_fail <= 1'h1; @(posedge aclk); main_osc_fail <= 1'h0; wait_boot(); cycles(2);
    rd(`OFS_CAUSE); `CHK(d, 32'h1001f)
    `CHK(nmi_seen, 1'h1)
    rd(`OFS_INT_STAT); `CHK(d, 32'h2)
  endtask
  task automatic t_por;
    aresetn <= 1'h0; cycles(3); `CHK(tap_rst_n, 1'h0)
    aresetn <= 1'h1; @(posedge aclk);
    rd(`OFS_CAUSE); `CHK(d, 32'h0000_0002)
    rd(`OFS_BOR_CTRL); `CHK(d, 32'h0)
  endtask

  initial begin
    cycles(10);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_start(); t_pin(); t_bor(); t_wdt(); t_sys(); t_periph(); t_osc(); t_por();
    end_of_test();
  end
endmodule
